// >>> hdl/esm_pkg.sv
`default_nettype none
package esm_pkg;

    // =========================================================
    // Address map of the core bus
    // =========================================================
    localparam logic [15:0] RAM_LO_BASE = 16'h0000;
    localparam logic [15:0] RAM_LO_TOP = 16'h01ff;
    localparam logic [15:0] RAM_HI_BASE = 16'h0200;
    localparam logic [15:0] RAM_HI_TOP = 16'h02ff;
    localparam logic [15:0] EP_LO_BASE = 16'hc000;
    localparam logic [15:0] EP_LO_TOP = 16'hdfff;
    localparam logic [15:0] EP_HI_BASE = 16'he000;
    localparam logic [15:0] EP_HI_TOP = 16'hffff;

    // =========================================================
    // Array and configuration bytes
    // =========================================================
    localparam int ARR_AW = 14;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] BLANK_BYTE = 8'hff;
    localparam logic CFG_MEM_IDX = 1'h0;
    localparam logic CFG_SEC_IDX = 1'h1;
    localparam logic [7:0] CFG_MEM_RESET = 8'hff;
    localparam logic [7:0] CFG_SEC_RESET = 8'hff;
    localparam int ROM_EN_BIT = 0;
    localparam int RAM_EN_BIT = 1;
    localparam int SEC_LSB = 0;
    localparam logic [7:0] SCRAMBLE_KEY = 8'h5a;

    // =========================================================
    // Types
    // =========================================================
    typedef enum logic [1:0] {
        SEC_0 = 2'h0,
        SEC_1 = 2'h1,
        SEC_2 = 2'h2,
        SEC_3 = 2'h3
    } esm_sec_e;

    typedef enum logic [1:0] {
        KIND_OPCODE = 2'h0,
        KIND_OPERAND = 2'h1,
        KIND_VECTOR = 2'h2,
        KIND_RSVD = 2'h3
    } esm_kind_e;

    typedef enum logic [2:0] {
        PST_IDLE = 3'h1,
        PST_READ = 3'h2,
        PST_DONE = 3'h4
    } esm_pst_e;

    typedef struct packed {
        logic valid;
        esm_kind_e kind;
        logic [15:0] addr;
    } esm_cpu_req_s;

    typedef struct packed {
        logic ram;
        logic eprom;
        logic external;
    } esm_sel_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic cfg;
        logic [ARR_AW-1:0] addr;
        logic [7:0] wdata;
    } esm_prog_req_s;

endpackage
`default_nettype wire

// >>> hdl/esm_scramble.sv
`timescale 1ns/10ps
`default_nettype none
// =========================================================
// Fixed per-location byte scrambler
// =========================================================
module esm_scramble (
    input wire logic [esm_pkg::ARR_AW-1:0] addr,
    input wire logic [7:0] din,
    output logic [7:0] dout
);
    logic [7:0] mask;

    // Same location always gives the same mask, so a dump is stable
    // but useless without the key and the mixing.
    always_comb begin
        mask = addr[7:0] ^ {addr[13:8], addr[1:0]} ^ esm_pkg::SCRAMBLE_KEY;
        mask = {mask[2:0], mask[7:3]} ^ {addr[5:0], addr[13:12]};
        dout = din ^ mask;
    end
endmodule
`default_nettype wire

// >>> hdl/esm_security.sv
`timescale 1ns/10ps
`default_nettype none
module esm_security (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic prog_mode,
    input wire logic external_memory_select,
    input wire esm_pkg::esm_cpu_req_s cpu_req,
    output esm_pkg::esm_sel_s cpu_sel,
    output logic [7:0] cpu_rdata,
    output logic cpu_rvalid,
    input wire esm_pkg::esm_prog_req_s prog_req,
    output logic prog_ready,
    output logic prog_ack,
    output logic prog_reject,
    output logic [7:0] prog_rdata,
    output logic [esm_pkg::ARR_AW-1:0] arr_addr,
    output logic arr_rd,
    output logic arr_we,
    output logic [7:0] arr_wdata,
    input wire logic [7:0] arr_rdata,
    output logic [1:0] security_level,
    output logic lower_eprom_half_enable,
    output logic upper_ram_half_enable,
    output logic ext_mode
);

    // =========================================================
    // Configuration bytes
    // =========================================================
    // Held in flops standing in for the EPROM cells; reset to the
    // erased pattern so an unprogrammed part is fully open.
    // Index 1 holds the security level, index 0 the memory map bits.
    logic [7:0] memory_config_byte_ff;
    logic [7:0] sec_config_byte_ff;
    esm_pkg::esm_sec_e level;
    logic level_open;
    logic level_rt_prot;

    // Decode is combinational off the stored byte, so a level write
    // governs the very next request.
    always_comb begin
        level = esm_pkg::esm_sec_e'(
            sec_config_byte_ff[esm_pkg::SEC_LSB +: 2]);
        level_open = (level == esm_pkg::SEC_3);
        // Runtime protection only at the two lowest levels; level 2
        // is write protection alone
        level_rt_prot = (level == esm_pkg::SEC_1) ||
                        (level == esm_pkg::SEC_0);
    end

    assign security_level = level;
    assign lower_eprom_half_enable =
        memory_config_byte_ff[esm_pkg::ROM_EN_BIT];
    assign upper_ram_half_enable =
        memory_config_byte_ff[esm_pkg::RAM_EN_BIT];
    // Erased bits read as 1, so a blank part has every half switched on.

    // =========================================================
    // External memory select, caught once after reset release
    // =========================================================
    // The pin doubles as the programming supply, so it is only taken
    // at the first edge after reset; later swings have no effect.
    // Swapping between internal and external code therefore needs a
    // fresh reset pulse.
    logic ext_ff;
    logic ext_taken_ff;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ext_ff <= 1'b0;
            ext_taken_ff <= 1'b0;
        end else if (!ext_taken_ff) begin
            ext_ff <= external_memory_select;
            ext_taken_ff <= 1'b1;
        end
    end

    assign ext_mode = ext_ff;

    // =========================================================
    // Address decode for the core
    // =========================================================
    logic hit_ram_lo;
    logic hit_ram_hi;
    logic hit_ep_lo;
    logic hit_ep_hi;
    logic int_eprom;
    logic int_ram;

    // Whatever is neither internal RAM nor enabled internal EPROM goes to
    // the external bus, the switched-off halves included.
    always_comb begin
        hit_ram_lo = (cpu_req.addr <= esm_pkg::RAM_LO_TOP);
        hit_ram_hi = (cpu_req.addr >= esm_pkg::RAM_HI_BASE) &&
                     (cpu_req.addr <= esm_pkg::RAM_HI_TOP);
        hit_ep_lo = (cpu_req.addr >= esm_pkg::EP_LO_BASE) &&
                    (cpu_req.addr <= esm_pkg::EP_LO_TOP);
        hit_ep_hi = (cpu_req.addr >= esm_pkg::EP_HI_BASE);
        int_ram = hit_ram_lo ||
                  (hit_ram_hi && upper_ram_half_enable);
        int_eprom = !ext_ff &&
                    (hit_ep_hi ||
                     (hit_ep_lo && lower_eprom_half_enable));

        // At most one select is high, and none in programming mode
        cpu_sel.ram = cpu_req.valid && !prog_mode && int_ram;
        cpu_sel.eprom = cpu_req.valid && !prog_mode && int_eprom;
        cpu_sel.external = cpu_req.valid && !prog_mode &&
                           !int_ram && !int_eprom;
    end

    // =========================================================
    // Opcode origin tracking
    // =========================================================
    // Remembers whether the instruction now executing was fetched
    // from on-chip EPROM; its operand reads are judged by this.
    // Vector fetches leave it alone: the interrupted code's origin
    // stays in force until the handler's first opcode is fetched.
    // Reset clears it, so operands before any opcode count as foreign.
    logic opcode_in_eprom_ff;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            opcode_in_eprom_ff <= 1'b0;
        end else if (cpu_req.valid && !prog_mode &&
                     cpu_req.kind == esm_pkg::KIND_OPCODE) begin
            opcode_in_eprom_ff <= int_eprom;
        end
    end

    // =========================================================
    // Core read path: array answers one cycle after the address
    // =========================================================
    logic cpu_block;
    logic s1_valid_ff;
    logic s1_block_ff;

    // The block decision is made with the request, since the origin
    // flag may already change with the next opcode fetch. Levels 3
    // and 2 never block anything.
    always_comb begin
        cpu_block = 1'b0;
        if (level_rt_prot) begin
            case (cpu_req.kind)
                // Jumps and branches only fetch opcodes: never blocked
                esm_pkg::KIND_OPCODE: cpu_block = 1'b0;
                esm_pkg::KIND_VECTOR: cpu_block = 1'b0;
                esm_pkg::KIND_OPERAND:
                    cpu_block = !opcode_in_eprom_ff;
                default: cpu_block = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s1_valid_ff <= 1'b0;
            s1_block_ff <= 1'b0;
        end else begin
            s1_valid_ff <= cpu_sel.eprom;
            s1_block_ff <= cpu_block;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_rdata <= esm_pkg::BLANK_BYTE;
            cpu_rvalid <= 1'b0;
        end else begin
            cpu_rvalid <= s1_valid_ff;
            // Data holds between answers; only rvalid marks a new byte
            if (s1_valid_ff) begin
                cpu_rdata <= s1_block_ff ? esm_pkg::BLANK_BYTE :
                             arr_rdata;
            end
        end
    end

    // =========================================================
    // Programmer port
    // =========================================================
    // Only served in programming mode; in normal running there is no
    // path at all to the configuration bytes.
    // One transfer at a time: ready stays low until the ack has gone,
    // so a source that keeps valid up is simply served again.
    esm_pkg::esm_pst_e pst_ff;
    esm_pkg::esm_pst_e nxt_pst;
    logic prog_take;
    logic prog_wr_ok;
    logic [esm_pkg::ARR_AW-1:0] prog_addr_ff;
    logic [7:0] scrambled;
    logic [7:0] cfg_sel_byte;

    assign prog_ready = (pst_ff == esm_pkg::PST_IDLE);
    assign prog_take = prog_ready && prog_mode && prog_req.valid;
    // Writes only at the open level
    assign prog_wr_ok = prog_take && prog_req.write &&
                        level_open;
    assign prog_ack = (pst_ff == esm_pkg::PST_DONE);
    // The low address bit picks one of the two configuration bytes
    assign cfg_sel_byte = (prog_req.addr[0] == esm_pkg::CFG_SEC_IDX) ?
                          sec_config_byte_ff : memory_config_byte_ff;

    // Fed from the registered address, so the mask has settled by the
    // time the array data comes back.
    esm_scramble u_scramble (
        .addr(prog_addr_ff),
        .din(arr_rdata),
        .dout(scrambled)
    );

    // Array reads spend one cycle waiting on the array; everything
    // else is answered one cycle after the take.
    always_comb begin
        nxt_pst = pst_ff;
        case (pst_ff)
            esm_pkg::PST_IDLE: begin
                if (prog_take) begin
                    if (!prog_req.write && !prog_req.cfg) begin
                        nxt_pst = esm_pkg::PST_READ;
                    end else begin
                        nxt_pst = esm_pkg::PST_DONE;
                    end
                end
            end
            esm_pkg::PST_READ: nxt_pst = esm_pkg::PST_DONE;
            esm_pkg::PST_DONE: nxt_pst = esm_pkg::PST_IDLE;
            default: nxt_pst = esm_pkg::PST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pst_ff <= esm_pkg::PST_IDLE;
        end else begin
            pst_ff <= nxt_pst;
        end
    end

    // The address is kept for the scrambler once valid has gone
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prog_addr_ff <= '0;
        end else if (prog_take) begin
            prog_addr_ff <= prog_req.addr;
        end
    end

    // A refusal is reported rather than silent, so a programmer can
    // tell a locked part from a cell that failed to program.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prog_reject <= 1'b0;
        end else if (prog_take) begin
            prog_reject <= prog_req.write &&
                           !level_open;
        end else if (pst_ff == esm_pkg::PST_DONE) begin
            prog_reject <= 1'b0;
        end
    end

    // Read data: configuration bytes are true at every level. The level
    // cannot move during a transfer, as no write is taken meanwhile.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prog_rdata <= esm_pkg::BLANK_BYTE;
        end else if (prog_take && !prog_req.write && prog_req.cfg) begin
            prog_rdata <= cfg_sel_byte;
        end else if (pst_ff == esm_pkg::PST_READ) begin
            case (level)
                esm_pkg::SEC_3: prog_rdata <= arr_rdata;
                esm_pkg::SEC_2: prog_rdata <= arr_rdata;
                esm_pkg::SEC_1: prog_rdata <= scrambled;
                esm_pkg::SEC_0:
                    prog_rdata <= esm_pkg::BLANK_BYTE;
                default: prog_rdata <= esm_pkg::BLANK_BYTE;
            endcase
        end
    end

    // Cells only go from 1 to 0, so a write ANDs into the byte. The
    // level can therefore only fall; in this flop model a reset brings
    // back the erased pattern, which a real cell would not do.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            memory_config_byte_ff <= esm_pkg::CFG_MEM_RESET;
            sec_config_byte_ff <= esm_pkg::CFG_SEC_RESET;
        end else if (prog_wr_ok && prog_req.cfg) begin
            if (prog_req.addr[0] == esm_pkg::CFG_SEC_IDX) begin
                sec_config_byte_ff <= sec_config_byte_ff &
                                      prog_req.wdata;
            end else begin
                memory_config_byte_ff <= memory_config_byte_ff &
                                         prog_req.wdata;
            end
        end
    end

    // =========================================================
    // Array port mux
    // =========================================================
    // Programming mode owns the array; the core never reaches it then.
    // Running mode never writes, and parks the write data at the erased
    // value so no stray zero can reach a cell.
    always_comb begin
        if (prog_mode) begin
            arr_addr = prog_req.addr;
            arr_rd = prog_take && !prog_req.write && !prog_req.cfg;
            arr_we = prog_wr_ok && !prog_req.cfg;
            arr_wdata = prog_req.wdata;
        end else begin
            arr_addr = cpu_req.addr[esm_pkg::ARR_AW-1:0];
            arr_rd = cpu_sel.eprom;
            arr_we = 1'b0;
            arr_wdata = esm_pkg::ERASED_BYTE;
        end
    end

endmodule
`default_nettype wire

// >>> test/esm_security_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// Port checks
// ====================
module esm_security_checker (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic prog_mode,
    input wire esm_pkg::esm_cpu_req_s cpu_req,
    input wire esm_pkg::esm_sel_s cpu_sel,
    input wire logic [7:0] cpu_rdata,
    input wire logic cpu_rvalid,
    input wire esm_pkg::esm_prog_req_s prog_req,
    input wire logic prog_ready,
    input wire logic prog_ack,
    input wire logic prog_reject,
    input wire logic [7:0] prog_rdata,
    input wire logic [1:0] security_level,
    input wire logic lower_eprom_half_enable,
    input wire logic ext_mode
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    logic run;
    assign run = cpu_req.valid && !prog_mode;
    // ====================
    // Steps
    // ====================
    sequence s_ram_op;
        run && cpu_req.kind == esm_pkg::KIND_OPCODE && !cpu_sel.eprom;
    endsequence
    sequence s_prot_rd;
        run && cpu_req.kind == esm_pkg::KIND_OPERAND && cpu_sel.eprom
            && !security_level[1];
    endsequence
    sequence s_wr_take;
        prog_ready && prog_mode && prog_req.valid && prog_req.write;
    endsequence
    sequence s_rd_take;
        prog_ready && prog_mode && prog_req.valid && !prog_req.write
            && !prog_req.cfg;
    endsequence
    // ====================
    // Properties
    // ====================
    property p_ram_lo;
        run && cpu_req.addr <= 16'h01ff |-> cpu_sel.ram;
    endproperty
    a_ram_lo: assert property (p_ram_lo)
        else $error("low RAM not selected");
    property p_ep_hi;
        run && cpu_req.addr >= 16'he000 && !ext_mode |-> cpu_sel.eprom;
    endproperty
    a_ep_hi: assert property (p_ep_hi)
        else $error("upper EPROM not selected");
    property p_lo_off;
        run && cpu_req.addr[15:13] == 3'h6 && !lower_eprom_half_enable
            |-> cpu_sel.external;
    endproperty
    a_lo_off: assert property (p_lo_off)
        else $error("disabled half still internal");
    property p_ext;
        run && cpu_req.addr[15:14] == 2'h3 && ext_mode
            |-> cpu_sel.external ##2 !cpu_rvalid;
    endproperty
    a_ext: assert property (p_ext)
        else $error("external select ignored");
    property p_quiet;
        !prog_mode [*3] |-> !prog_ack;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("programmer served in running mode");
    property p_rvalid;
        run && cpu_sel.eprom |-> ##2 cpu_rvalid;
    endproperty
    a_rvalid: assert property (p_rvalid)
        else $error("EPROM read not answered");
    property p_prot;
        s_ram_op ##1 s_prot_rd |-> ##2 cpu_rvalid && cpu_rdata == 8'hff;
    endproperty
    a_prot: assert property (p_prot)
        else $error("protected operand leaked");
    property p_wr_rej;
        s_wr_take ##0 security_level != 2'h3 |=> prog_ack && prog_reject;
    endproperty
    a_wr_rej: assert property (p_wr_rej)
        else $error("locked write not refused");
    property p_lvl0;
        s_rd_take ##0 security_level == 2'h0
            |-> ##2 prog_ack && prog_rdata == 8'hff;
    endproperty
    a_lvl0: assert property (p_lvl0)
        else $error("level 0 array read not blank");
endmodule
bind esm_security esm_security_checker esm_security_checker_i (
    .mclk(mclk), .rst_b(rst_b), .prog_mode(prog_mode),
    .cpu_req(cpu_req), .cpu_sel(cpu_sel), .cpu_rdata(cpu_rdata),
    .cpu_rvalid(cpu_rvalid), .prog_req(prog_req),
    .prog_ready(prog_ready), .prog_ack(prog_ack),
    .prog_reject(prog_reject), .prog_rdata(prog_rdata),
    .security_level(security_level), .ext_mode(ext_mode),
    .lower_eprom_half_enable(lower_eprom_half_enable)
);
`default_nettype wire

// >>> test/esm_array_model.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// Array model, one-cycle synchronous read
// ====================
module esm_array_model (
    input wire logic mclk,
    input wire logic [esm_pkg::ARR_AW-1:0] arr_addr,
    input wire logic arr_rd,
    input wire logic arr_we,
    input wire logic [7:0] arr_wdata,
    output logic [7:0] arr_rdata
);
    logic [7:0] mem_ff [1 << esm_pkg::ARR_AW];
    initial begin
        foreach (mem_ff[i]) mem_ff[i] = 8'hff;
        arr_rdata = 8'h00;
    end
    always @(posedge mclk) begin
        // Cells only program towards zero
        if (arr_we) mem_ff[arr_addr] <= mem_ff[arr_addr] & arr_wdata;
        // Idle cycles invert, so stale data never passes for a read
        arr_rdata <= arr_rd ? mem_ff[arr_addr] : ~arr_rdata;
    end
endmodule
`default_nettype wire

// >>> test/tb_esm_security.sv
`timescale 1ns/10ps
`default_nettype none
module tb_esm_security;
    localparam esm_pkg::esm_kind_e OPC = esm_pkg::KIND_OPCODE;
    localparam esm_pkg::esm_kind_e OPR = esm_pkg::KIND_OPERAND;
    localparam esm_pkg::esm_kind_e VEC = esm_pkg::KIND_VECTOR;
    localparam esm_pkg::esm_kind_e RSV = esm_pkg::KIND_RSVD;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic prog_mode = 1'b0;
    logic external_memory_select = 1'b0;
    esm_pkg::esm_cpu_req_s cpu_req = '0;
    esm_pkg::esm_prog_req_s prog_req = '0;
    esm_pkg::esm_sel_s cpu_sel;
    logic [7:0] cpu_rdata, prog_rdata, arr_wdata, arr_rdata, stat, rd, x;
    logic cpu_rvalid, prog_ready, prog_ack, prog_reject, arr_rd, arr_we;
    logic lower_eprom_half_enable, upper_ram_half_enable, ext_mode;
    logic [13:0] arr_addr;
    logic [1:0] security_level;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    // Address, then select for: all on, both halves off, external
    logic [24:0] map [9] = '{
        {16'h0000, 9'h124}, {16'h01ff, 9'h124}, {16'h0200, 9'h10c},
        {16'h02ff, 9'h10c}, {16'h0300, 9'h049}, {16'hc000, 9'h089},
        {16'hdfff, 9'h089}, {16'he000, 9'h091}, {16'hffff, 9'h091}
    };
    assign stat = {3'h0, security_level, upper_ram_half_enable,
                   lower_eprom_half_enable, ext_mode};
    always #10 mclk = ~mclk;
    esm_security esm_security_i (
        .mclk(mclk), .rst_b(rst_b), .prog_mode(prog_mode),
        .external_memory_select(external_memory_select),
        .cpu_req(cpu_req), .cpu_sel(cpu_sel), .cpu_rdata(cpu_rdata),
        .cpu_rvalid(cpu_rvalid), .prog_req(prog_req),
        .prog_ready(prog_ready), .prog_ack(prog_ack),
        .prog_reject(prog_reject), .prog_rdata(prog_rdata),
        .arr_addr(arr_addr), .arr_rd(arr_rd), .arr_we(arr_we),
        .arr_wdata(arr_wdata), .arr_rdata(arr_rdata),
        .security_level(security_level), .ext_mode(ext_mode),
        .lower_eprom_half_enable(lower_eprom_half_enable),
        .upper_ram_half_enable(upper_ram_half_enable)
    );
    esm_array_model esm_array_model_i (
        .mclk(mclk), .arr_addr(arr_addr), .arr_rd(arr_rd),
        .arr_we(arr_we), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata)
    );
    // ====================
    // Tasks
    // ====================
    task automatic chk(input logic [7:0] g, input logic [7:0] e,
                       input string what);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD at %0t: %s got %h want %h", $time, what, g, e);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic do_reset(input logic ext);
        @(negedge mclk);
        rst_b = 1'b0;
        prog_mode = 1'b0;
        external_memory_select = ext;
        repeat (10) @(negedge mclk);
        rst_b = 1'b1;
        repeat (2) @(negedge mclk);
    endtask
    // Valid is held for the take edge only, else it would be taken again
    task automatic pxfer(input logic w, input logic c,
                         input logic [13:0] a, input logic [7:0] d);
        int n;
        n = 0;
        prog_req = '{1'b1, w, c, a, d};
        @(negedge mclk);
        prog_req.valid = 1'b0;
        while (prog_ack !== 1'b1 && n < 4) begin
            @(negedge mclk);
            n++;
        end
        if (n == 4) chk(8'h00, 8'h01, "no ack");
        rd = w ? {7'h0, prog_reject} : prog_rdata;
        @(negedge mclk);
    endtask
    task automatic prog(input logic w, input logic c, input logic [13:0] a,
                        input logic [7:0] d, input logic [7:0] e);
        pxfer(w, c, a, d);
        chk(rd, e, "prog");
    endtask
    task automatic set_level(input logic [7:0] b);
        do_reset(1'b0);
        prog_mode = 1'b1;
        @(negedge mclk);
        prog(1'b1, 1'b1, 14'h0001, b, 8'h00);
    endtask
    // Two back-to-back accesses; the second must be an EPROM hit
    task automatic cpu2(input esm_pkg::esm_kind_e k0, input logic [15:0] a0,
                        input esm_pkg::esm_kind_e k1, input logic [15:0] a1,
                        input logic [7:0] e);
        cpu_req = '{1'b1, k0, a0};
        @(negedge mclk);
        cpu_req = '{1'b1, k1, a1};
        @(negedge mclk);
        cpu_req.valid = 1'b0;
        @(negedge mclk);
        chk({7'h0, cpu_rvalid}, 8'h01, "rvalid");
        chk(cpu_rdata, e, "cpu data");
    endtask
    task automatic map_chk(input int col);
        for (int i = 0; i < 9; i++) begin
            cpu_req = '{1'b1, OPR, map[i][24:9]};
            #1;
            chk({5'h0, cpu_sel}, {5'h0, map[i][8-3*col -: 3]}, "map");
            @(negedge mclk);
        end
        cpu_req.valid = 1'b0;
        repeat (3) @(negedge mclk);
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            final_report();
        end
    end
    // ====================
    // Tests
    // ====================
    initial begin
        do_reset(1'b0);
        chk(stat, 8'h1e, "reset");
        map_chk(0);
        prog_mode = 1'b1;
        @(negedge mclk);
        prog(1'b1, 1'b0, 14'h3ff0, 8'h5c, 8'h00);
        prog(1'b0, 1'b0, 14'h3ff0, 8'h00, 8'h5c);
        prog(1'b1, 1'b1, 14'h0000, 8'hfc, 8'h00);
        prog(1'b0, 1'b1, 14'h0000, 8'h00, 8'hfc);
        prog_mode = 1'b0;
        @(negedge mclk);
        chk(stat, 8'h18, "halves");
        map_chk(1);
        cpu2(OPC, 16'h0100, OPR, 16'hfff0, 8'h5c);
        $display("test level 3 done");
        set_level(8'hfe);
        chk(stat, 8'h16, "level");
        prog(1'b1, 1'b0, 14'h3ff0, 8'h00, 8'h01);
        prog(1'b0, 1'b0, 14'h3ff0, 8'h00, 8'h5c);
        prog(1'b0, 1'b1, 14'h0001, 8'h00, 8'hfe);
        prog_mode = 1'b0;
        @(negedge mclk);
        cpu2(OPC, 16'h0100, OPR, 16'hfff0, 8'h5c);
        $display("test level 2 done");
        for (int lv = 1; lv >= 0; lv--) begin
            x = {6'h3f, lv[1:0]};
            set_level(x);
            chk(stat, {3'h0, lv[1:0], 3'h6}, "level");
            prog(1'b1, 1'b0, 14'h3ff0, 8'h00, 8'h01);
            prog(1'b0, 1'b1, 14'h0001, 8'h00, x);
            pxfer(1'b0, 1'b0, 14'h3ff0, 8'h00);
            x = rd;
            pxfer(1'b0, 1'b0, 14'h3ff0, 8'h00);
            if (lv == 1) begin
                chk({7'h0, x == 8'h5c}, 8'h00, "plain");
                chk(rd, x, "repeat");
            end else begin
                chk(x, 8'hff, "blank");
            end
            prog_mode = 1'b0;
            prog_req = '{1'b1, 1'b0, 1'b1, 14'h0001, 8'h00};
            repeat (3) @(negedge mclk);
            chk({7'h0, prog_ack}, 8'h00, "cfg hidden");
            prog_req.valid = 1'b0;
            @(negedge mclk);
            cpu2(OPC, 16'h0100, OPR, 16'hfff0, 8'hff);
            cpu2(OPC, 16'he000, OPR, 16'hfff0, 8'h5c);
            cpu2(OPC, 16'h0100, VEC, 16'hfff0, 8'h5c);
            cpu2(OPC, 16'h0100, RSV, 16'hfff0, 8'h5c);
            cpu2(OPC, 16'h0100, OPC, 16'hfff0, 8'h5c);
            $display("test level %0d done", lv);
        end
        do_reset(1'b1);
        chk(stat, 8'h1f, "ext");
        map_chk(2);
        $display("test external select done");
        final_report();
    end
endmodule
`default_nettype wire
